/* File: rtl/pss_seq.sv */
// PA supply step-start sequencer with APB register slave.
// Assumes 10 MHz pclk; contactor feedback, buttons, remote and
// mismatch pins are asynchronous and are synchronised here.
// Operation
// [RULE1] Panel low/med/high/off buttons and remote inputs request on or off.
// [RULE2] Turn-on first energizes the surge-limit contactor.
// [RULE3] Surge-limit contactor aux contact returns a closed feedback.
// [RULE4] One second after surge energize, energize the run contactor.
// [RULE5] Run contactor aux contact returns a closed feedback.
// [RULE6] Half a second after run closes, drop the surge-limit contactor.
// [RULE7] Steady on: surge-limit off, run contactor on.
// [RULE8] Discharge on whenever both contactors off, open while energized.
// [RULE9] Mismatch forces all amplifier control outputs off at once.
// [RULE10] Inhibit lasts only while mismatch present, no restart sequence.
// [RULE11] Fault indications latch until explicit reset, even when off.
// [RULE12] Status kept through mains loss; restart when mains returns.
// [RULE13] Provide 26 status indications, each also a remote output.
// [RULE14] Phase loss or imbalance switches supply off, flags supply fault.
// [RULE15] Off request at any point drops both contactors at once.
// [RULE16] Missing contactor feedback within bound aborts turn-on with fault.
`timescale 1ns/1ns
`default_nettype none
module pss_seq
	import pss_pkg::*;
#(
	parameter int STEP_CYC = STEP_DELAY_CYC,
	parameter int SETTLE_CYC = RUN_SETTLE_CYC,
	parameter int FB_CYC = FB_TIMEOUT_CYC,
	parameter int AMP_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic btn_low,
	input wire logic btn_med,
	input wire logic btn_high,
	input wire logic btn_off,
	input wire logic remote_on,
	input wire logic remote_off,
	input wire logic surge_closed,
	input wire logic run_closed,
	input wire logic load_mismatch,
	input wire logic phase_fault,
	input wire logic mains_ok,
	input wire logic [AMP_W-1:0] amp_ctrl_in,
	input wire logic [pss_pkg::NUM_STATUS-1:0] status_in,
	output logic surge_limit_contactor,
	output logic run_contactor,
	output logic discharge_on,
	output logic amp_inhibit,
	output logic [AMP_W-1:0] amp_ctrl,
	output logic [pss_pkg::NUM_STATUS-1:0] status_led,
	output logic [pss_pkg::NUM_STATUS-1:0] remote_status,
	output logic irq
);
	import pss_pkg::*;

	localparam int CW = 32;
	localparam int NPIN = 10 + NUM_STATUS;

	// Surge feedback is only watched while the surge step lasts
	if (STEP_CYC < 1 || SETTLE_CYC < 1 || FB_CYC < 1) begin : g_bad_delay
		$error("pss_seq: delay counts must be at least one");
	end
	if (FB_CYC >= STEP_CYC) begin : g_bad_fb
		$error("pss_seq: feedback bound must be below step delay");
	end
	if (AMP_W < 1) begin : g_bad_width
		$error("pss_seq: AMP_W must be positive");
	end

	typedef struct packed {
		pss_state_e st;
		logic [CW-1:0] cnt;
		logic [CW-1:0] fb_cnt;
		logic restart_pend;
		logic was_mains;
		logic auto_restart;
		logic [2:0] faults;
		logic [NUM_STATUS-1:0] stat_latch;
		logic [NUM_EV-1:0] ev_stat;
		logic [NUM_EV-1:0] ev_mask;
		logic inhibit_q;
		logic [31:0] rdata;
	} pss_seq_s;

	pss_seq_s r;
	pss_seq_s next_r;

	pss_sync_if #(.W(NPIN)) sif ();
	pss_sync #(.W(NPIN)) i_pss_sync (
		.pclk(pclk),
		.presetn(presetn),
		.sif(sif)
	);

	assign sif.raw = {status_in, mains_ok, phase_fault, load_mismatch,
		run_closed, surge_closed, remote_off, remote_on, btn_off,
		btn_high, btn_med | btn_low};

	logic s_btn_on;
	logic s_btn_high;
	logic s_btn_off;
	logic s_rem_on;
	logic s_rem_off;
	logic s_surge_fb;
	logic s_run_fb;
	logic s_mismatch;
	logic s_phase;
	logic s_mains;
	logic [NUM_STATUS-1:0] s_status;

	assign s_btn_on = sif.synced[0];
	assign s_btn_high = sif.synced[1];
	assign s_btn_off = sif.synced[2];
	assign s_rem_on = sif.synced[3];
	assign s_rem_off = sif.synced[4];
	assign s_surge_fb = sif.synced[5];
	assign s_run_fb = sif.synced[6];
	assign s_mismatch = sif.synced[7];
	assign s_phase = sif.synced[8];
	assign s_mains = sif.synced[9];
	assign s_status = sif.synced[NPIN-1:10];

	logic apb_wr;
	logic apb_rd;
	logic on_req;
	logic off_req;
	logic flt_reset;
	logic [NUM_EV-1:0] ev_set;
	logic [NUM_EV-1:0] ev_clr;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;

	always_comb begin
		next_r = r;
		on_req = 1'b0;
		off_req = 1'b0;
		flt_reset = 1'b0;
		ev_set = '0;
		ev_clr = '0;

		// Any panel on button (low, med, high) or remote_on can start the supply
		on_req = s_btn_on || s_btn_high || s_rem_on; // [RULE1]
		off_req = s_btn_off || s_rem_off; // [RULE1]

		if (apb_wr && paddr == ADDR_CTRL) begin
			on_req = on_req || pwdata[CTRL_ON_BIT];
			off_req = off_req || pwdata[CTRL_OFF_BIT];
			flt_reset = pwdata[CTRL_FAULT_RESET_BIT];
			next_r.auto_restart = pwdata[CTRL_AUTO_RESTART_BIT];
		end
		if (apb_wr && paddr == ADDR_IRQ_STAT) begin
			ev_clr = pwdata[NUM_EV-1:0];
		end
		if (apb_wr && paddr == ADDR_IRQ_MASK) begin
			next_r.ev_mask = pwdata[NUM_EV-1:0];
		end

		// Mains loss drops the supply but remembers it was wanted
		next_r.was_mains = s_mains;
		if (!s_mains && r.st != PSS_OFF && r.auto_restart) begin
			next_r.restart_pend = 1'b1; // [RULE12]
		end
		if (s_mains && !r.was_mains && r.restart_pend) begin
			on_req = 1'b1; // [RULE12]
			next_r.restart_pend = 1'b0;
		end
		if (off_req) begin
			next_r.restart_pend = 1'b0;
		end

		// Reset clears before this cycle's faults latch, so a set wins
		if (flt_reset) begin
			next_r.faults = '0; // [RULE11]
		end

		next_r.cnt = r.cnt + 32'h0000_0001;
		next_r.fb_cnt = r.fb_cnt + 32'h0000_0001;

		case (r.st)
			PSS_OFF: begin
				if (on_req && !off_req && s_mains && !s_phase) begin
					next_r.st = PSS_SURGE; // [RULE2]
					next_r.cnt = '0;
					next_r.fb_cnt = '0;
				end
			end
			PSS_SURGE: begin
				if (!s_surge_fb && r.fb_cnt >= 32'(FB_CYC)) begin
					next_r.st = PSS_OFF; // [RULE16]
					next_r.faults[FLT_SURGE_FB] = 1'b1;
					ev_set[EV_FB_FAULT] = 1'b1;
				end else if (r.cnt >= 32'(STEP_CYC - 1)) begin
					next_r.st = PSS_RUN_WAIT; // [RULE4]
					next_r.fb_cnt = '0;
				end
			end
			PSS_RUN_WAIT: begin
				if (s_run_fb) begin // [RULE5]
					next_r.st = PSS_OVERLAP;
					next_r.cnt = '0;
				end else if (r.fb_cnt >= 32'(FB_CYC)) begin
					next_r.st = PSS_OFF; // [RULE16]
					next_r.faults[FLT_RUN_FB] = 1'b1;
					ev_set[EV_FB_FAULT] = 1'b1;
				end
			end
			PSS_OVERLAP: begin
				if (r.cnt >= 32'(SETTLE_CYC - 1)) begin
					next_r.st = PSS_ON; // [RULE6]
					ev_set[EV_RUNNING] = 1'b1;
				end
			end
			PSS_ON: begin
				if (!s_run_fb) begin
					next_r.st = PSS_OFF;
					next_r.faults[FLT_RUN_FB] = 1'b1;
					ev_set[EV_FB_FAULT] = 1'b1;
				end
			end
			default: begin
				next_r.st = PSS_OFF;
			end
		endcase

		// Abort overrides every step, including pending delays
		if (r.st != PSS_OFF && (off_req || !s_mains)) begin
			next_r.st = PSS_OFF; // [RULE15]
			ev_set[EV_OFF] = 1'b1;
		end
		if (r.st != PSS_OFF && s_phase) begin
			next_r.st = PSS_OFF; // [RULE14]
			ev_set[EV_SUPPLY_FAULT] = 1'b1;
		end
		if (s_phase) begin
			next_r.faults[FLT_SUPPLY] = 1'b1; // [RULE14]
		end

		next_r.inhibit_q = s_mismatch;
		if (s_mismatch && !r.inhibit_q) begin
			ev_set[EV_INHIBIT] = 1'b1;
		end

		// Latch survives turn-off; only an explicit reset clears it
		if (flt_reset) begin
			next_r.stat_latch = s_status; // [RULE11]
		end else begin
			next_r.stat_latch = r.stat_latch | s_status; // [RULE11]
		end

		// Set wins over a same-cycle clear
		next_r.ev_stat = (r.ev_stat & ~ev_clr) | ev_set;

		if (apb_rd) begin
			case (paddr)
				ADDR_CTRL: next_r.rdata = {28'h0000000, r.auto_restart,
					3'b000};
				ADDR_STATE: next_r.rdata = {24'h000000, s_mains, s_phase,
					s_mismatch, s_run_fb, s_surge_fb, r.st};
				ADDR_IRQ_STAT: next_r.rdata = {27'h0000000, r.ev_stat};
				ADDR_IRQ_MASK: next_r.rdata = {27'h0000000, r.ev_mask};
				ADDR_FAULT: next_r.rdata = {3'b000, r.faults,
					r.stat_latch};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	// Backup-powered store modelled by keeping state across mains loss;
	// only presetn (backup loss) clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{st: PSS_OFF, cnt: '0, fb_cnt: '0,
				restart_pend: 1'b0, was_mains: 1'b0,
				auto_restart: CTRL_RESET_VAL[CTRL_AUTO_RESTART_BIT],
				faults: '0, stat_latch: '0, ev_stat: '0, ev_mask: '0,
				inhibit_q: 1'b0, rdata: '0};
		end else begin
			r <= next_r;
		end
	end

	logic amp_block;

	// One gate per module line; a mismatch drops every line together
	for (genvar gi = 0; gi < AMP_W; gi++) begin : g_amp_gate
		assign amp_ctrl[gi] = amp_ctrl_in[gi] && !amp_block; // [RULE9]
	end

	always_comb begin
		surge_limit_contactor = (r.st == PSS_SURGE) ||
			(r.st == PSS_RUN_WAIT) || (r.st == PSS_OVERLAP); // [RULE2]
		run_contactor = (r.st == PSS_RUN_WAIT) || (r.st == PSS_OVERLAP) ||
			(r.st == PSS_ON); // [RULE7]
		discharge_on = (r.st == PSS_OFF); // [RULE8]
		// Combinational so the inhibit acts with only the sync delay
		amp_inhibit = s_mismatch; // [RULE9]
		amp_block = s_mismatch || r.st != PSS_ON; // [RULE10]
		status_led = {r.stat_latch[NUM_STATUS-1:3], r.faults}; // [RULE13]
		remote_status = {r.stat_latch[NUM_STATUS-1:3], r.faults}; // [RULE13]
		irq = |(r.ev_stat & r.ev_mask);
		prdata = r.rdata;
		pready = 1'b1;
		pslverr = 1'b0;
	end
endmodule // pss_seq
`default_nettype wire

/* File: rtl/pss_pkg.sv */
// Package for the PA supply step-start sequencer.
// Assumes a single 10 MHz pclk domain; all times derived from CLK_HZ.
package pss_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int STEP_DELAY_MS = 1000;
	localparam int RUN_SETTLE_MS = 500;
	localparam int FB_TIMEOUT_MS = 200;
	localparam int STEP_DELAY_CYC = CLK_HZ / 1000 * STEP_DELAY_MS;
	localparam int RUN_SETTLE_CYC = CLK_HZ / 1000 * RUN_SETTLE_MS;
	localparam int FB_TIMEOUT_CYC = CLK_HZ / 1000 * FB_TIMEOUT_MS;
	localparam int NUM_STATUS = 26;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATE = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADDR_FAULT = 8'h10;

	// Control register fields
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_OFF_BIT = 1;
	localparam int CTRL_FAULT_RESET_BIT = 2;
	localparam int CTRL_AUTO_RESTART_BIT = 3;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0008;

	// Event / sticky status bits
	localparam int EV_RUNNING = 0;
	localparam int EV_OFF = 1;
	localparam int EV_FB_FAULT = 2;
	localparam int EV_SUPPLY_FAULT = 3;
	localparam int EV_INHIBIT = 4;
	localparam int NUM_EV = 5;

	// Latched fault bits in the fault store
	localparam int FLT_SURGE_FB = 0;
	localparam int FLT_RUN_FB = 1;
	localparam int FLT_SUPPLY = 2;

	typedef enum logic [2:0] {
		PSS_OFF = 3'b000,
		PSS_SURGE = 3'b001,
		PSS_RUN_WAIT = 3'b010,
		PSS_OVERLAP = 3'b011,
		PSS_ON = 3'b100
	} pss_state_e;
endpackage

/* File: rtl/pss_sync_if.sv */
// Interface carrying synchronised pin levels between top and synchroniser.
// Assumes all pins are asynchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
interface pss_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface
`default_nettype wire

/* File: rtl/pss_sync.sv */
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes presetn asynchronous active low; pins settle to inactive low.
`timescale 1ns/1ns
`default_nettype none
module pss_sync #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	pss_sync_if.snk sif
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} pss_sync_s;
	pss_sync_s r;
	pss_sync_s next_r;

	always_comb begin
		next_r = r;
		next_r.meta = sif.raw;
		next_r.stab = r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sif.synced = r.stab;
endmodule // pss_sync
`default_nettype wire

/* File: test/pss_seq_checker.sv */
// Port checker for pss_seq.
// Assumes bind to pss_seq with its delay parameters passed on.
`timescale 1ns/1ns
`default_nettype none
module pss_seq_checker
	import pss_pkg::*;
#(
	parameter int STEP_CYC = 40,
	parameter int FB_CYC = 10,
	parameter int SETTLE_CYC = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic btn_off,
	input wire logic phase_fault,
	input wire logic run_closed,
	input wire logic surge_limit_contactor,
	input wire logic run_contactor,
	input wire logic discharge_on,
	input wire logic amp_inhibit,
	input wire logic [7:0] amp_ctrl_in,
	input wire logic [7:0] amp_ctrl,
	input wire logic [pss_pkg::NUM_STATUS-1:0] status_led,
	input wire logic [pss_pkg::NUM_STATUS-1:0] remote_status
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int step_cnt;
	int wait_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt <= 0;
			wait_cnt <= 0;
		end else begin
			step_cnt <= (surge_limit_contactor && !run_contactor) ? step_cnt + 1 : 0;
			wait_cnt <= (run_contactor && !run_closed) ? wait_cnt + 1 : 0;
		end
	end
	a_dis_path: assert property (
		discharge_on == !(surge_limit_contactor || run_contactor))
		else $error("discharge level disagrees with contactors");
	a_surge_first: assert property (
		$rose(surge_limit_contactor) |-> !run_contactor)
		else $error("run contactor on before surge contactor");
	a_step_delay: assert property (
		$rose(run_contactor) |-> step_cnt == STEP_CYC)
		else $error("run contactor joined at wrong time");
	a_settle_gap: assert property (
		$fell(surge_limit_contactor) && run_contactor |->
		$past(run_closed, SETTLE_CYC))
		else $error("surge contactor dropped too early");
	a_inhibit_gate: assert property (
		amp_inhibit |-> amp_ctrl == 8'h00)
		else $error("amp outputs live while inhibited");
	a_ctrl_resume: assert property (
		!amp_inhibit && run_contactor && !surge_limit_contactor |->
		amp_ctrl == amp_ctrl_in)
		else $error("amp outputs not passed while on");
	a_off_prompt: assert property (
		btn_off [*4] |-> discharge_on)
		else $error("off request did not drop contactors");
	a_phase_trip: assert property (
		phase_fault [*4] |-> !surge_limit_contactor && !run_contactor)
		else $error("phase fault did not drop supply");
	a_fb_bound: assert property (
		wait_cnt <= FB_CYC + 3)
		else $error("run feedback wait unbounded");
	a_remote_copy: assert property (
		remote_status == status_led)
		else $error("remote status differs from panel");
endmodule // pss_seq_checker
`default_nettype wire

/* File: test/pss_contactors.sv */
// Model of the two contactors and their auxiliary contacts.
// Assumes coil levels from pss_seq; slow delays closing, stuck_run never closes.
`timescale 1ns/1ns
`default_nettype none
module pss_contactors (
	input wire logic pclk,
	input wire logic surge_coil,
	input wire logic run_coil,
	input wire logic slow,
	input wire logic stuck_run,
	output logic surge_closed,
	output logic run_closed
);
	logic [5:0] s_sr;
	logic [5:0] r_sr;
	always_ff @(posedge pclk) begin
		s_sr <= {s_sr[4:0], surge_coil};
		r_sr <= {r_sr[4:0], run_coil && !stuck_run};
	end
	// Contact opens with the coil at once, closes late
	assign surge_closed = surge_coil && (slow ? s_sr[5] : s_sr[1]);
	assign run_closed = run_coil && (slow ? r_sr[5] : r_sr[1]);
endmodule // pss_contactors
`default_nettype wire

/* File: test/pss_seq_bench.sv */
// Self-checking bench for pss_seq with the contactor model.
// Assumes delays cut to 40, 20 and 10 cycles of a 10 MHz pclk.
`timescale 1ns/1ns
`default_nettype none
module pss_seq_bench;
	import pss_pkg::*;
	localparam int STEP_CYC = 40;
	localparam int SETTLE_CYC = 20;
	localparam int FB_CYC = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, amp_ctrl_in, amp_ctrl;
	logic [31:0] pwdata, prdata, rd;
	logic btn_low, btn_med, btn_high, btn_off, remote_on, remote_off;
	logic surge_closed, run_closed, load_mismatch, phase_fault, mains_ok;
	logic slow, stuck_run, surge_limit_contactor, run_contactor;
	logic discharge_on, amp_inhibit, err;
	logic [NUM_STATUS-1:0] status_in, status_led, remote_status;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	pss_seq #(.STEP_CYC(STEP_CYC), .SETTLE_CYC(SETTLE_CYC), .FB_CYC(FB_CYC))
		i_pss_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .btn_low, .btn_med, .btn_high,
		.btn_off, .remote_on, .remote_off, .surge_closed, .run_closed,
		.load_mismatch, .phase_fault, .mains_ok, .amp_ctrl_in, .status_in,
		.surge_limit_contactor, .run_contactor, .discharge_on, .amp_inhibit,
		.amp_ctrl, .status_led, .remote_status, .irq);
	pss_contactors i_pss_contactors (.pclk, .surge_coil(surge_limit_contactor),
		.run_coil(run_contactor), .slow, .stuck_run, .surge_closed, .run_closed);
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic wait_on();
		while (run_contactor !== 1'b1 || surge_limit_contactor !== 1'b0)
			@(posedge pclk);
		settle(1);
	endtask
	task automatic t_on_seq();
		int n;
		apb(0, ADDR_CTRL, 0);
		chk("ctrl reset", rd, CTRL_RESET_VAL);
		apb(0, 8'h40, 0);
		chk("unmapped read", rd, 32'h0);
		chk("no slverr", err, 1'b0);
		apb(1, ADDR_IRQ_MASK, 32'h0000_001F);
		apb(1, ADDR_CTRL, 32'h0000_0009);
		settle(STEP_CYC - 2);
		chk("surge first", surge_limit_contactor, 1'b1);
		chk("run early", run_contactor, 1'b0);
		chk("discharge open", discharge_on, 1'b0);
		settle(4);
		chk("run joins", run_contactor, 1'b1);
		n = 0;
		while (surge_limit_contactor !== 1'b0) begin
			@(posedge pclk);
			n++;
		end
		settle(2);
		chk("overlap", n >= SETTLE_CYC && n <= SETTLE_CYC + 8, 1'b1);
		chk("steady", {surge_limit_contactor, run_contactor}, 2'b01);
		chk("on irq", irq, 1'b1);
		apb(0, ADDR_STATE, 0);
		chk("state on", rd[2:0], 3'h4);
		apb(1, ADDR_IRQ_STAT, 32'h0000_001F);
		settle(1);
		chk("irq clear", irq, 1'b0);
		$display("turn-on test done");
	endtask
	task automatic t_inhibit();
		@(posedge pclk);
		amp_ctrl_in <= 8'hA5;
		load_mismatch <= 1;
		settle(3);
		chk("amp gated", amp_ctrl, 8'h00);
		chk("inhibit", amp_inhibit, 1'b1);
		@(posedge pclk);
		load_mismatch <= 0;
		settle(3);
		chk("amp back", {run_contactor, amp_ctrl}, 9'h1A5);
		@(posedge pclk);
		phase_fault <= 1;
		settle(5);
		chk("phase trip", {surge_limit_contactor, run_contactor, discharge_on},
			3'b001);
		chk("supply fault", status_led[FLT_SUPPLY], 1'b1);
		@(posedge pclk);
		phase_fault <= 0;
		$display("inhibit and phase test done");
	endtask
	task automatic t_mains();
		apb(1, ADDR_CTRL, 32'h0000_0009);
		wait_on();
		@(posedge pclk);
		mains_ok <= 0;
		settle(5);
		chk("mains loss", discharge_on, 1'b1);
		@(posedge pclk);
		slow <= 1;
		mains_ok <= 1;
		wait_on();
		chk("restart", run_contactor, 1'b1);
		slow <= 0;
		// Auto-restart off: mains return must leave the supply off
		apb(1, ADDR_CTRL, 32'h0000_0001);
		@(posedge pclk);
		mains_ok <= 0;
		settle(4);
		@(posedge pclk);
		mains_ok <= 1;
		settle(8);
		chk("no restart", discharge_on, 1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			{btn_low, btn_med, btn_high, remote_on} <= 4'b1000 >> i;
			settle(6);
			chk("on source", surge_limit_contactor, 1'b1);
			@(posedge pclk);
			{btn_low, btn_med, btn_high, remote_on} <= 4'h0;
			{btn_off, remote_off} <= i[0] ? 2'b01 : 2'b10;
			settle(4);
			chk("off mid", {surge_limit_contactor, run_contactor}, 2'b00);
			@(posedge pclk);
			{btn_off, remote_off} <= 2'b00;
			settle(4);
		end
		$display("mains and button test done");
	endtask
	task automatic t_fault();
		@(posedge pclk);
		stuck_run <= 1;
		status_in <= 26'h0000200;
		apb(1, ADDR_CTRL, 32'h0000_0009);
		settle(STEP_CYC + FB_CYC + 8);
		chk("abort", {surge_limit_contactor, run_contactor}, 2'b00);
		@(posedge pclk);
		stuck_run <= 0;
		status_in <= '0;
		settle(4);
		chk("held", status_led, 26'h0000206);
		chk("remote", remote_status, 26'h0000206);
		apb(0, ADDR_FAULT, 0);
		chk("fault reg", rd, 32'h1800_0200);
		apb(0, ADDR_IRQ_STAT, 0);
		chk("events", rd, 32'h0000_001F);
		chk("irq", irq, 1'b1);
		apb(1, ADDR_CTRL, 32'h0000_000C);
		settle(2);
		chk("fault reset", status_led, 26'h0);
		$display("fault test done");
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{btn_low, btn_med, btn_high, btn_off, remote_on, remote_off} = '0;
		{load_mismatch, phase_fault, slow, stuck_run, status_in} = '0;
		mains_ok = 1;
		amp_ctrl_in = 8'h3C;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_on_seq();
		t_inhibit();
		t_mains();
		t_fault();
		report_and_stop();
	end
endmodule // pss_seq_bench
bind pss_seq pss_seq_checker #(.STEP_CYC(STEP_CYC), .FB_CYC(FB_CYC),
	.SETTLE_CYC(SETTLE_CYC)) i_chk (.pclk, .presetn, .btn_off, .phase_fault,
	.run_closed, .surge_limit_contactor, .run_contactor, .discharge_on,
	.amp_inhibit, .amp_ctrl_in, .amp_ctrl, .status_led, .remote_status);
`default_nettype wire
